// ===== core/core_consts.svh
// constants for the core register and indirect access block
`ifndef CORE_CONSTS_SVH
`define CORE_CONSTS_SVH

// register offsets
`define OFS_PORT0 7'h00
`define OFS_PORT1 7'h01
`define OFS_PCL 7'h02
`define OFS_STATUS 7'h03
`define OFS_PTR0_LO 7'h04
`define OFS_PTR0_HI 7'h05
`define OFS_PTR1_LO 7'h06
`define OFS_PTR1_HI 7'h07
`define OFS_BANK 7'h08
`define OFS_WORKING_ACCUMULATOR 7'h09
`define OFS_COUNTER_HIGH_LATCH 7'h0A

// status bit positions
`define ST_EXPIRY 4
`define ST_SLEEP 3
`define ST_ZERO 2
`define ST_NIBBLE 1
`define ST_CARRY 0

// pointer regions
`define PTR_FLASH_BIT 15
`define PTR_EE_PAGE 8'h70
`define DM_LIMIT 16'h2000

// reset values
`define RST_BYTE 8'h00
`define RST_PTR 16'h0000
`define RST_PC 15'h0000
`define RST_BANK 6'h00
`define RST_LATCH 7'h00

`endif

// ===== core/core_pkg.sv
// types shared by the core register block
package core_pkg;
    typedef enum logic [1:0] {
        ALU_ADD = 2'b00,
        ALU_SUB = 2'b01,
        ALU_RLC = 2'b10,
        ALU_RRC = 2'b11
    } alu_op_e;

    typedef enum logic [1:0] {
        TGT_DATA = 2'b00,
        TGT_FLASH = 2'b01,
        TGT_EE = 2'b10,
        TGT_SELF = 2'b11
    } target_e;
endpackage

// ===== core/flag_alu.sv
// adder and rotator that produce result and flags
`timescale 1ns/100ps
`default_nettype none
module flag_alu
    import core_pkg::*;
(
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic carry_in,
    input wire alu_op_e op,
    // results
    output logic [7:0] result,
    output logic zero,
    output logic nibble_out,
    output logic carry_out
);
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] b_eff;
    logic c_eff;

    always_comb begin
        // subtract is add of two's complement, flags become not-borrow
        b_eff = (op == ALU_SUB) ? ~b : b;
        c_eff = (op == ALU_SUB);
        sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, c_eff};
        low_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
        result = sum[7:0];
        nibble_out = low_sum[4];
        carry_out = sum[8];
        case (op)
            ALU_RLC: begin
                result = {a[6:0], carry_in};
                carry_out = a[7];
                nibble_out = 1'b0;
            end
            ALU_RRC: begin
                result = {carry_in, a[7:1]};
                carry_out = a[0];
                nibble_out = 1'b0;
            end
            default: begin
            end
        endcase
        zero = (result == 8'h00);
    end
endmodule
`default_nettype wire

// ===== core/pointer_decode.sv
// classifies an indirect pointer into its target region
`timescale 1ns/100ps
`default_nettype none
`include "core_consts.svh"
module pointer_decode
    import core_pkg::*;
(
    // pointer
    input wire logic [15:0] ptr,
    // decoded target
    output target_e target,
    output logic [14:0] flash_addr,
    output logic [7:0] ee_addr
);
    always_comb begin
        flash_addr = ptr[14:0];
        ee_addr = ptr[7:0];
        if (ptr[`PTR_FLASH_BIT]) begin
            target = TGT_FLASH;
        end else if (ptr[15:8] == `PTR_EE_PAGE) begin
            target = TGT_EE;
        end else if (ptr[15:1] == 15'h0000) begin
            target = TGT_SELF;
        end else begin
            target = TGT_DATA;
        end
    end
endmodule
`default_nettype wire

// ===== core/core_indirect_access_regs.sv
// core special function registers with indirect access path
`timescale 1ns/100ps
`default_nettype none
`include "core_consts.svh"
// Behaviour
// - pointer bit 15 set selects flash at the low fifteen pointer bits.
// - flash reads return only the low byte of the flash word.
// - writes through a port aimed at flash are dropped.
// - flash indirect reads cost one extra instruction cycle.
// - pointer high byte 0x70 reads EEPROM at the pointer low byte.
// - writes through a port aimed at EEPROM are dropped.
// - EEPROM indirect reads cost one extra instruction cycle.
// - ports hold nothing; port 0 uses pointer 0, port 1 pointer 1.
// - counter low byte register reads and writes program counter 7:0.
// - expiry flag set at power-up, kick or sleep; cleared on timeout.
// - sleep flag set at power-up or kick; cleared by sleep.
// - zero, nibble and carry flags clear only on power-on/brown-out.
// - zero flag shows whether the operation result is zero.
// - nibble flag takes carry out of bit 3 on add and subtract.
// - carry flag takes carry out of bit 7 on add and subtract.
// - subtract adds two's complement so carries mean no borrow.
// - rotate through carry puts the shifted-out bit into carry.
// - each pointer is two separately addressed bytes, high and low.
// - bank number is six bits and tops every direct address.
// - high latch holds seven bits; writing it leaves counter alone.
// - writing the counter low byte loads counter 14:8 from latch.
// - a pointer aimed at a port reads zero and drops writes.
module core_indirect_access_regs
    import core_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic por_reset,
    // special register access from the execution unit
    input wire logic [6:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic stall,
    // program counter control
    input wire logic pc_advance,
    input wire logic pc_load,
    input wire logic [14:0] pc_load_value,
    output logic [14:0] program_counter,
    // arithmetic and flag events
    input wire logic alu_en,
    input wire alu_op_e alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic alu_to_working_accumulator,
    input wire logic logic_zero_en,
    input wire logic [7:0] logic_result,
    input wire logic watchdog_kick_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    // flash and eeprom read ports
    output logic [14:0] flash_addr,
    output logic flash_rd,
    input wire logic [13:0] flash_rdata,
    output logic [7:0] ee_addr,
    output logic ee_rd,
    input wire logic [7:0] ee_rdata,
    // banked data memory path
    output logic [12:0] dm_addr,
    output logic dm_rd,
    output logic dm_wr,
    output logic [7:0] dm_wdata,
    input wire logic [7:0] dm_rdata,
    input wire logic [6:0] direct_offset,
    output logic [12:0] direct_addr,
    // register views
    output logic [7:0] status_flags,
    output logic [7:0] working_accumulator,
    output logic [5:0] bank_number
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] pointer_zero_q;
    logic [15:0] pointer_one_q;
    logic [14:0] pc_q;
    logic [6:0] counter_high_latch_q;
    logic [5:0] bank_number_q;
    logic [7:0] working_accumulator_q;
    logic zero_q, nibble_q, carry_q;
    logic expiry_q, sleep_q;
    logic stall_q;
    logic [7:0] nv_data_q;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [6:0] a, input logic [6:0] o);
        hit = (a == o);
    endfunction

    logic port_access, port_sel;
    logic [15:0] sel_ptr;
    target_e target;
    logic [14:0] dec_flash;
    logic [7:0] dec_ee;
    logic nv_access;
    logic wr_ok;

    assign port_sel = hit(sfr_addr, `OFS_PORT1);
    assign port_access = (hit(sfr_addr, `OFS_PORT0) || port_sel)
        && (sfr_rd || sfr_wr);
    assign sel_ptr = port_sel ? pointer_one_q : pointer_zero_q;

    pointer_decode u_decode (
        .ptr(sel_ptr),
        .target(target),
        .flash_addr(dec_flash),
        .ee_addr(dec_ee)
    );

    assign nv_access = port_access && sfr_rd &&
        ((target == TGT_FLASH) || (target == TGT_EE));
    assign stall = nv_access && !stall_q;

    // writes into flash, eeprom or ports dropped
    assign wr_ok = sfr_wr && !stall;

    // ------------------------------------------------------------
    // nonvolatile and data memory paths
    // ------------------------------------------------------------
    // flash addressed by low fifteen bits
    assign flash_addr = dec_flash;
    assign flash_rd = stall && (target == TGT_FLASH);
    assign ee_addr = dec_ee;
    assign ee_rd = stall && (target == TGT_EE);
    assign dm_addr = sel_ptr[12:0];
    assign dm_rd = port_access && sfr_rd && (target == TGT_DATA)
        && (sel_ptr < `DM_LIMIT);
    assign dm_wr = port_access && wr_ok && (target == TGT_DATA)
        && (sel_ptr < `DM_LIMIT);
    assign dm_wdata = sfr_wdata;
    // bank number forms top six address bits
    assign direct_addr = {bank_number_q, direct_offset};

    // capture nonvolatile data during the stall cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stall_q <= 1'b0;
            nv_data_q <= `RST_BYTE;
        end else begin
            stall_q <= stall;
            if (flash_rd) begin
                // only low byte of the flash word
                nv_data_q <= flash_rdata[7:0];
            end else if (ee_rd) begin
                nv_data_q <= ee_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0] port_rdata;
    always_comb begin
        case (target)
            TGT_FLASH: port_rdata = nv_data_q;
            TGT_EE: port_rdata = nv_data_q;
            // port aimed at a port reads zero
            TGT_SELF: port_rdata = 8'h00;
            default: port_rdata = (sel_ptr < `DM_LIMIT) ? dm_rdata : 8'h00;
        endcase
    end

    always_comb begin
        case (sfr_addr)
            `OFS_PORT0, `OFS_PORT1: sfr_rdata = port_rdata;
            `OFS_PCL: sfr_rdata = pc_q[7:0];
            `OFS_STATUS: sfr_rdata = status_flags;
            `OFS_PTR0_LO: sfr_rdata = pointer_zero_q[7:0];
            `OFS_PTR0_HI: sfr_rdata = pointer_zero_q[15:8];
            `OFS_PTR1_LO: sfr_rdata = pointer_one_q[7:0];
            `OFS_PTR1_HI: sfr_rdata = pointer_one_q[15:8];
            `OFS_BANK: sfr_rdata = {2'b00, bank_number_q};
            `OFS_WORKING_ACCUMULATOR: sfr_rdata = working_accumulator_q;
            `OFS_COUNTER_HIGH_LATCH: sfr_rdata = {1'b0, counter_high_latch_q};
            default: sfr_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // pointers, bank, latch
    // ------------------------------------------------------------
    // byte writes to pointer halves
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pointer_zero_q <= `RST_PTR;
            pointer_one_q <= `RST_PTR;
        end else if (wr_ok) begin
            if (hit(sfr_addr, `OFS_PTR0_LO)) pointer_zero_q[7:0] <= sfr_wdata;
            if (hit(sfr_addr, `OFS_PTR0_HI)) pointer_zero_q[15:8] <= sfr_wdata;
            if (hit(sfr_addr, `OFS_PTR1_LO)) pointer_one_q[7:0] <= sfr_wdata;
            if (hit(sfr_addr, `OFS_PTR1_HI)) pointer_one_q[15:8] <= sfr_wdata;
        end
    end

    // latch write leaves the counter untouched
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            counter_high_latch_q <= `RST_LATCH;
            bank_number_q <= `RST_BANK;
        end else if (wr_ok) begin
            if (hit(sfr_addr, `OFS_COUNTER_HIGH_LATCH)) begin
                counter_high_latch_q <= sfr_wdata[6:0];
            end
            if (hit(sfr_addr, `OFS_BANK)) begin
                bank_number_q <= sfr_wdata[5:0];
            end
        end
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pc_q <= `RST_PC;
        end else if (wr_ok && hit(sfr_addr, `OFS_PCL)) begin
            pc_q <= {counter_high_latch_q, sfr_wdata};
        end else if (pc_load) begin
            pc_q <= pc_load_value;
        end else if (pc_advance && !stall) begin
            pc_q <= pc_q + 15'h0001;
        end
    end

    // ------------------------------------------------------------
    // arithmetic flags and accumulator
    // ------------------------------------------------------------
    logic [7:0] alu_result;
    logic alu_zero, alu_nibble, alu_carry;

    flag_alu u_alu (
        .a(alu_a),
        .b(alu_b),
        .carry_in(carry_q),
        .op(alu_op),
        .result(alu_result),
        .zero(alu_zero),
        .nibble_out(alu_nibble),
        .carry_out(alu_carry)
    );

    logic st_wr;
    assign st_wr = wr_ok && hit(sfr_addr, `OFS_STATUS);

    // only the power-on reset clears these flags
    always_ff @(posedge core_clk or posedge por_reset) begin
        if (por_reset) begin
            zero_q <= 1'b0;
            nibble_q <= 1'b0;
            carry_q <= 1'b0;
        end else if (alu_en) begin
            zero_q <= alu_zero;
            if (alu_op == ALU_ADD || alu_op == ALU_SUB) begin
                nibble_q <= alu_nibble;
            end
            carry_q <= alu_carry;
        end else if (logic_zero_en) begin
            zero_q <= (logic_result == 8'h00);
        end else if (st_wr) begin
            zero_q <= sfr_wdata[`ST_ZERO];
            nibble_q <= sfr_wdata[`ST_NIBBLE];
            carry_q <= sfr_wdata[`ST_CARRY];
        end
    end

    always_ff @(posedge core_clk or posedge por_reset) begin
        if (por_reset) begin
            expiry_q <= 1'b1;
            sleep_q <= 1'b1;
        end else begin
            if (watchdog_timeout) begin
                expiry_q <= 1'b0;
            end else if (watchdog_kick_instr || sleep_instr) begin
                expiry_q <= 1'b1;
            end
            if (sleep_instr) begin
                sleep_q <= 1'b0;
            end else if (watchdog_kick_instr) begin
                sleep_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            working_accumulator_q <= `RST_BYTE;
        end else if (alu_en && alu_to_working_accumulator) begin
            working_accumulator_q <= alu_result;
        end else if (wr_ok && hit(sfr_addr, `OFS_WORKING_ACCUMULATOR)) begin
            working_accumulator_q <= sfr_wdata;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign status_flags = {3'b000, expiry_q, sleep_q, zero_q, nibble_q,
        carry_q};
    assign program_counter = pc_q;
    assign working_accumulator = working_accumulator_q;
    assign bank_number = bank_number_q;
endmodule
`default_nettype wire

// ===== verif/core_mem_model.sv
// flash, eeprom and data memory model facing the core block
`timescale 1ns/100ps
`default_nettype none
module core_mem_model (
    // clock
    input wire logic core_clk,
    // flash and eeprom read side
    input wire logic [14:0] flash_addr,
    input wire logic flash_rd,
    output logic [13:0] flash_rdata,
    input wire logic [7:0] ee_addr,
    input wire logic ee_rd,
    output logic [7:0] ee_rdata,
    // banked data memory
    input wire logic [12:0] dm_addr,
    input wire logic dm_rd,
    input wire logic dm_wr,
    input wire logic [7:0] dm_wdata,
    output logic [7:0] dm_rdata
);
    logic [7:0] mem [0:8191];
    logic tog = 1'b0;
    // idle lines flip every cycle so stale data never looks valid
    always @(posedge core_clk) begin
        tog <= ~tog;
        if (dm_wr) mem[dm_addr] <= dm_wdata;
    end
    assign flash_rdata = flash_rd ? (flash_addr[13:0] ^ 14'h3c5a) : {14{tog}};
    assign ee_rdata = ee_rd ? (ee_addr ^ 8'h96) : {8{tog}};
    assign dm_rdata = dm_rd ? mem[dm_addr] : {8{tog}};
endmodule
`default_nettype wire

// ===== verif/core_indirect_access_regs_monitor.sv
// port assertions for the core register block
`timescale 1ns/100ps
`default_nettype none
`include "core_consts.svh"
module core_indirect_access_regs_monitor
    import core_pkg::*;
(
    // clock and resets
    input wire logic core_clk,
    input wire logic reset,
    input wire logic por_reset,
    // register access and program counter
    input wire logic [6:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic stall,
    input wire logic pc_advance,
    input wire logic pc_load,
    input wire logic [14:0] program_counter,
    // arithmetic and events
    input wire logic alu_en,
    input wire alu_op_e alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic watchdog_kick_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    // memory side and views
    input wire logic flash_rd,
    input wire logic ee_rd,
    input wire logic dm_wr,
    input wire logic [7:0] dm_wdata,
    input wire logic [6:0] direct_offset,
    input wire logic [12:0] direct_addr,
    input wire logic [7:0] status_flags,
    input wire logic [5:0] bank_number
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset || por_reset);
    logic [8:0] add_w, sub_w;
    logic [2:0] add_f, sub_f;
    logic rot_c;
    assign add_w = {1'b0, alu_a} + {1'b0, alu_b};
    assign sub_w = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
    assign add_f[1] = ({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}) > 5'h0f;
    assign sub_f[1] = ({1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01) > 5'h0f;
    assign add_f[2] = add_w[7:0] == 8'h00;
    assign sub_f[2] = sub_w[7:0] == 8'h00;
    assign add_f[0] = add_w[8];
    assign sub_f[0] = sub_w[8];
    assign rot_c = (alu_op == ALU_RLC) ? alu_a[7] : alu_a[0];
    property p_stall_once;
        stall |=> !stall;
    endproperty
    a_stall_once: assert property (p_stall_once)
        else $error("stall lasted more than one cycle");
    property p_nv_stall;
        (flash_rd || ee_rd) |-> stall && !(flash_rd && ee_rd);
    endproperty
    a_nv_stall: assert property (p_nv_stall)
        else $error("nonvolatile read without a single stall");
    property p_nv_nowrite;
        stall |-> !dm_wr;
    endproperty
    a_nv_nowrite: assert property (p_nv_nowrite)
        else $error("memory write during nonvolatile access");
    property p_direct;
        direct_addr == {bank_number, direct_offset};
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct address not built from bank");
    property p_pcl;
        sfr_wr && !stall && sfr_addr == `OFS_PCL
            |=> program_counter[7:0] == $past(sfr_wdata);
    endproperty
    a_pcl: assert property (p_pcl)
        else $error("counter low byte not written");
    property p_latch;
        sfr_wr && sfr_addr == `OFS_COUNTER_HIGH_LATCH && !pc_advance && !pc_load
            |=> $stable(program_counter);
    endproperty
    a_latch: assert property (p_latch)
        else $error("latch write moved the counter");
    property p_port_wdata;
        sfr_wr && dm_wr && sfr_addr inside {`OFS_PORT0, `OFS_PORT1}
            |-> dm_wdata == sfr_wdata;
    endproperty
    a_port_wdata: assert property (p_port_wdata)
        else $error("port write data not passed on");
    property p_add;
        alu_en && alu_op == ALU_ADD |=> status_flags[2:0] == $past(add_f);
    endproperty
    a_add: assert property (p_add)
        else $error("add flags wrong");
    property p_sub;
        alu_en && alu_op == ALU_SUB |=> status_flags[2:0] == $past(sub_f);
    endproperty
    a_sub: assert property (p_sub)
        else $error("subtract flags wrong");
    property p_rot;
        alu_en && alu_op inside {ALU_RLC, ALU_RRC}
            |=> status_flags[`ST_CARRY] == $past(rot_c);
    endproperty
    a_rot: assert property (p_rot)
        else $error("rotate carry wrong");
    property p_timeout;
        watchdog_timeout |=> !status_flags[`ST_EXPIRY];
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("expiry flag not cleared on timeout");
    property p_sleep;
        sleep_instr && !watchdog_kick_instr && !watchdog_timeout
            |=> status_flags[4:3] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep did not set flags");
    // power-on values are checked while the reset itself is held
    property p_por;
        disable iff (1'b0) por_reset |-> status_flags[4:0] == 5'h18;
    endproperty
    a_por: assert property (p_por)
        else $error("power-on flag values wrong");
    c_flash: cover property (flash_rd);
    c_ee: cover property (ee_rd);
    c_dm_wr: cover property (dm_wr);
endmodule
bind core_indirect_access_regs
    core_indirect_access_regs_monitor u_core_indirect_access_regs_monitor (.*);
`default_nettype wire

// ===== verif/tb_core_indirect_access_regs.sv
// self-checking bench for the core register block
`timescale 1ns/100ps
`default_nettype none
`include "core_consts.svh"
module tb_core_indirect_access_regs
    import core_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b0;
    logic por_reset = 1'b0;
    logic [6:0] sfr_addr = 7'h00, direct_offset = 7'h00;
    logic sfr_rd = 1'b0, sfr_wr = 1'b0, pc_advance = 1'b0, pc_load = 1'b0;
    logic [7:0] sfr_wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
    logic [7:0] logic_result = 8'h00;
    logic alu_en = 1'b0, alu_to_working_accumulator = 1'b0, logic_zero_en = 1'b0;
    logic watchdog_kick_instr = 1'b0, sleep_instr = 1'b0;
    logic watchdog_timeout = 1'b0;
    logic [14:0] pc_load_value = 15'h0000;
    alu_op_e alu_op = ALU_ADD;
    logic [7:0] sfr_rdata, ee_addr, ee_rdata, dm_wdata, dm_rdata;
    logic [7:0] status_flags, working_accumulator, seen_ea;
    logic stall, flash_rd, ee_rd, dm_rd, dm_wr;
    logic [14:0] program_counter, flash_addr, seen_fa;
    logic [13:0] flash_rdata;
    logic [12:0] dm_addr, direct_addr, seen_dm;
    logic [5:0] bank_number;
    int num_errors = 0, checks_done = 0, dm_writes = 0;
    core_indirect_access_regs u_core_indirect_access_regs (.*);
    core_mem_model u_core_mem_model (.*);
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (dm_wr === 1'b1) dm_writes <= dm_writes + 1;
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask
    // a port read aimed at flash or eeprom answers one cycle late
    task automatic rdc(input logic [6:0] a, input logic [7:0] e, input logic es);
        logic s;
        @(posedge core_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        #1 s = stall;
        seen_dm = dm_addr;
        seen_fa = flash_addr;
        seen_ea = ee_addr;
        if (s === 1'b1) begin
            @(posedge core_clk);
            #1;
        end
        chk(sfr_rdata, e);
        chk(s, es);
        @(posedge core_clk);
        sfr_rd <= 1'b0;
    endtask
    task automatic setp(input int n, input logic [15:0] v);
        wr((n != 0) ? `OFS_PTR1_LO : `OFS_PTR0_LO, v[7:0]);
        wr((n != 0) ? `OFS_PTR1_HI : `OFS_PTR0_HI, v[15:8]);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] d, lat, av, bv, r, e;
        logic [15:0] p;
        logic [15:0] pv [2];
        logic [8:0] sm;
        logic c, dc;
        alu_op_e op;
        int i, n, base;
        i = $urandom(25941);
        // a real rising edge so the asynchronous resets take hold at once
        {reset, por_reset} <= 2'b11;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        por_reset <= 1'b0;
        for (i = 0; i <= 10; i++) begin
            rdc(7'(i), (i == 3) ? 8'h18 : 8'h00, 1'b0);
        end
        lat = 8'($urandom);
        wr(`OFS_COUNTER_HIGH_LATCH, lat);
        rdc(`OFS_COUNTER_HIGH_LATCH, lat & 8'h7f, 1'b0);
        chk(program_counter, 15'h0000);
        d = 8'($urandom);
        direct_offset <= 7'($urandom);
        wr(`OFS_BANK, d);
        rdc(`OFS_BANK, d & 8'h3f, 1'b0);
        chk(direct_addr, {d[5:0], direct_offset});
        @(posedge core_clk);
        pc_load_value <= 15'($urandom);
        pc_load <= 1'b1;
        @(posedge core_clk);
        pc_load <= 1'b0;
        pc_advance <= 1'b1;
        @(posedge core_clk);
        pc_advance <= 1'b0;
        #1 chk(program_counter, pc_load_value + 15'h0001);
        d = 8'($urandom);
        wr(`OFS_PCL, d);
        #1 chk(program_counter, {lat[6:0], d});
        rdc(`OFS_PCL, d, 1'b0);
        // offsets from 0x20 keep clear of core registers seen in every bank
        for (n = 0; n < 2; n++) begin
            pv[n] = {3'b000, 6'($urandom), 7'h20 + 7'($urandom % 80)};
            pv[n][12] = n[0];
            setp(n, pv[n]);
            wr(7'(n), pv[n][7:0] ^ 8'h33);
        end
        for (n = 0; n < 2; n++) begin
            rdc(7'(n), pv[n][7:0] ^ 8'h33, 1'b0);
            chk(seen_dm, pv[n][12:0]);
            rdc(`OFS_PTR0_HI + 7'(2 * n), pv[n][15:8], 1'b0);
        end
        for (i = 0; i < 8; i++) begin
            n = i % 2;
            if (i < 2) p = 16'(i);
            else if (i < 4) p = 16'h8000 | 16'($urandom);
            else p = {8'h70, (i == 4) ? 8'h00 : (i == 5) ? 8'hff : 8'($urandom)};
            e = (i < 2) ? 8'h00 : (i < 4) ? p[7:0] ^ 8'h5a : p[7:0] ^ 8'h96;
            setp(n, p);
            base = dm_writes;
            wr(7'(n), 8'($urandom));
            #1 chk(16'(dm_writes - base), 16'h0000);
            rdc(7'(n), e, i >= 2);
            if (i == 2 || i == 3) chk(seen_fa, p[14:0]);
            if (i >= 4) chk(seen_ea, p[7:0]);
        end
        c = 1'b0;
        dc = 1'b0;
        for (i = 0; i < 24; i++) begin
            op = alu_op_e'(i % 4);
            av = 8'($urandom);
            bv = (i % 8 == 0) ? 8'h00 - av : (i % 8 == 1) ? av : 8'($urandom);
            case (op)
                ALU_ADD: sm = {1'b0, av} + {1'b0, bv};
                ALU_SUB: sm = {1'b0, av} + {1'b0, ~bv} + 9'h001;
                ALU_RLC: sm = {av, c};
                default: sm = {av[0], c, av[7:1]};
            endcase
            if (op == ALU_ADD) dc = ({1'b0, av[3:0]} + {1'b0, bv[3:0]}) > 5'h0f;
            if (op == ALU_SUB) dc = ({1'b0, av[3:0]} + {1'b0, ~bv[3:0]}) >= 5'h0f;
            c = sm[8];
            r = sm[7:0];
            @(posedge core_clk);
            alu_en <= 1'b1;
            alu_op <= op;
            alu_a <= av;
            alu_b <= bv;
            alu_to_working_accumulator <= 1'b1;
            @(posedge core_clk);
            alu_en <= 1'b0;
            #1 chk(status_flags[2:0], {r == 8'h00, dc, c});
            chk(working_accumulator, r);
        end
        for (i = 0; i < 2; i++) begin
            @(posedge core_clk);
            logic_zero_en <= 1'b1;
            logic_result <= 8'(i);
            @(posedge core_clk);
            logic_zero_en <= 1'b0;
            #1 chk(status_flags[`ST_ZERO], i == 0);
        end
        wr(`OFS_STATUS, 8'h07);
        rdc(`OFS_STATUS, 8'h1f, 1'b0);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rdc(`OFS_STATUS, 8'h1f, 1'b0);
        rdc(`OFS_WORKING_ACCUMULATOR, 8'h00, 1'b0);
        for (i = 0; i < 3; i++) begin
            @(posedge core_clk);
            watchdog_timeout <= (i == 0);
            sleep_instr <= (i == 1);
            watchdog_kick_instr <= (i == 2);
            @(posedge core_clk);
            {watchdog_timeout, sleep_instr, watchdog_kick_instr} <= 3'b000;
            #1 chk(status_flags[4:3], (i == 0) ? 2'b01 : (i == 1) ? 2'b10 : 2'b11);
        end
        give_verdict();
    end
    // the run needs well under a thousand cycles
    initial begin
        #75000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
